// >>> hw/prs_debounce.sv
// two-stage synchroniser followed by a stable-count debouncer for one contact
`timescale 1ns/1ps
`default_nettype none
module prs_debounce
  import prs_pkg::*;
#(
  parameter int unsigned CYCLES = 400000
) (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic nrst_i,
  // contact
  input  wire logic pin_i,
  output logic      level_o
);
  prs_deb_t st;
  prs_deb_t next_st;

  // level changes only after the synced pin differs for CYCLES clocks
  always_comb begin
    next_st    = st;
    next_st.s1 = pin_i;
    next_st.s2 = st.s1;
    if (st.s2 == st.level) begin
      next_st.cnt = 32'h0;
    end else if (st.cnt == 32'(CYCLES - 1)) begin
      next_st.level = st.s2;
      next_st.cnt   = 32'h0;
    end else begin
      next_st.cnt = st.cnt + 32'h1;
    end
    if (!nrst_i) begin
      next_st = '0;
    end
  end

  always_ff @(posedge clk_i) begin
    st <= next_st;
  end

  assign level_o = st.level;
endmodule
`default_nettype wire

// >>> hw/prs_params.svh
// constants of the pump run sequencer: timing, addresses, fields, reset values
`ifndef PRS_PARAMS_SVH
`define PRS_PARAMS_SVH
`define PRS_CLK_HZ       40000000
`define PRS_PWRUP_MS     4000
`define PRS_PWRUP_CYC    (`PRS_PWRUP_MS * (`PRS_CLK_HZ / 1000))
`define PRS_DEB_MS       10
`define PRS_DEB_CYC      (`PRS_DEB_MS * (`PRS_CLK_HZ / 1000))
`define PRS_SEC_CYC      `PRS_CLK_HZ
`define PRS_SECS_PER_MIN 14'h003c
`define PRS_RUN_MIN_RST  8'h0a
`define PRS_CTRL_RST     4'h1
`define PRS_ADDR_CTRL    8'h00
`define PRS_ADDR_TIMER   8'h04
`define PRS_ADDR_STATUS  8'h08
`define PRS_CTRL_TMR_FIT 0
`define PRS_CTRL_BYPASS  1
`define PRS_CTRL_DELUGE  2
`define PRS_CTRL_LOCKOUT 3
`define PRS_NIN          11
`define PRS_IN_LINE      0
`define PRS_IN_ALLP      1
`define PRS_IN_SEQ       2
`define PRS_IN_CPWR      3
`define PRS_IN_PLOW      4
`define PRS_IN_STOP      5
`define PRS_IN_START     6
`define PRS_IN_REMOTE    7
`define PRS_IN_DELUGE    8
`define PRS_IN_LOCK      9
`define PRS_IN_EMERG     10
`endif

// >>> hw/prs_pkg.sv
// types of the pump run sequencer
package prs_pkg;
  typedef enum logic [2:0] {
    TMR_IDLE = 3'b001,
    TMR_RUN  = 3'b010,
    TMR_DONE = 3'b100
  } prs_tmr_t;

  typedef struct packed {
    logic        s1;
    logic        s2;
    logic        level;
    logic [31:0] cnt;
  } prs_deb_t;

  typedef struct packed {
    logic        line_q;
    logic        rot_ok;
    logic        ph_ok;
    logic [31:0] pwr_cnt;
    logic        delay_done;
    logic        rev_lamp;
    logic        rev_relay;
    logic        pwr_lamp;
    logic        pwr_relay;
    logic        pump_alarm;
    logic        loss_alarm;
    logic        revs_alarm;
    logic        auto_run;
    logic        manual;
    logic        contactor;
    prs_tmr_t    tmr;
    logic [31:0] sec_cnt;
    logic [15:0] run_sec;
    logic [3:0]  ctrl;
    logic [7:0]  minutes;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } prs_state_t;
endpackage

// >>> hw/prs_sequencer.sv
// pump run sequencer: phase monitor, power-up delay, run latches, alarms, apb
`timescale 1ns/1ps
`default_nettype none
`include "prs_params.svh"
module prs_sequencer
  import prs_pkg::*;
#(
  parameter int unsigned PWRUP_CYCLES = `PRS_PWRUP_CYC,
  parameter int unsigned DEB_CYCLES   = `PRS_DEB_CYC,
  parameter int unsigned SEC_CYCLES   = `PRS_SEC_CYC
) (
  // clock and reset
  input  wire logic        MCLK_I,
  input  wire logic        NRST_I,
  // apb slave
  input  wire logic        PSEL_I,
  input  wire logic        PENABLE_I,
  input  wire logic        PWRITE_I,
  input  wire logic [7:0]  PADDR_I,
  input  wire logic [31:0] PWDATA_I,
  output logic             PREADY_O,
  output logic             PSLVERR_O,
  output logic [31:0]      PRDATA_O,
  // line sensing pins
  input  wire logic        LINE_LIVE_I,
  input  wire logic        PHASES_ALL_I,
  input  wire logic        SEQ_ABC_I,
  input  wire logic        CTRL_PWR_I,
  // field contacts
  input  wire logic        PRESSURE_LOW_I,
  input  wire logic        STOP_PB_I,
  input  wire logic        START_PB_I,
  input  wire logic        REMOTE_START_I,
  input  wire logic        DELUGE_CLOSED_I,
  input  wire logic        LOCKOUT_I,
  input  wire logic        EMERG_RUN_I,
  // phase monitor outputs
  output logic             ROT_OK_O,
  output logic             PHASE_PRESENT_O,
  // lamps and relays
  output logic             REV_LAMP_O,
  output logic             REV_RELAY_O,
  output logic             POWER_LAMP_O,
  output logic             POWER_RELAY_O,
  output logic             AUTO_RUN_O,
  output logic             CONTACTOR_O,
  // alarm contacts
  output logic             PUMP_RUN_ALARM_O,
  output logic             PHASE_LOSS_ALARM_O,
  output logic             PHASE_REV_ALARM_O
);
  prs_state_t            st;
  prs_state_t            next_st;
  logic [`PRS_NIN-1:0]   raw;
  logic [`PRS_NIN-1:0]   d;
  logic                  stop;
  logic                  lock;
  logic                  auto_req;
  logic                  hold;
  logic                  fitted;
  logic                  bypass;
  logic [15:0]           limit;
  logic                  setup;
  logic                  wr;

  // pins gathered so one generate covers them all
  always_comb begin
    raw                   = '0;
    raw[`PRS_IN_LINE]     = LINE_LIVE_I;
    raw[`PRS_IN_ALLP]     = PHASES_ALL_I;
    raw[`PRS_IN_SEQ]      = SEQ_ABC_I;
    raw[`PRS_IN_CPWR]     = CTRL_PWR_I;
    raw[`PRS_IN_PLOW]     = PRESSURE_LOW_I;
    raw[`PRS_IN_STOP]     = STOP_PB_I;
    raw[`PRS_IN_START]    = START_PB_I;
    raw[`PRS_IN_REMOTE]   = REMOTE_START_I;
    raw[`PRS_IN_DELUGE]   = DELUGE_CLOSED_I;
    raw[`PRS_IN_LOCK]     = LOCKOUT_I;
    raw[`PRS_IN_EMERG]    = EMERG_RUN_I;
  end

  // every pin is synchronised and debounced; costs two synchroniser clocks plus DEB_CYCLES of latency
  for (genvar i = 0; i < `PRS_NIN; i++) begin : g_deb
    prs_debounce #(
      .CYCLES (DEB_CYCLES)
    ) u_deb (
      .clk_i   (MCLK_I),
      .nrst_i  (NRST_I),
      .pin_i   (raw[i]),
      .level_o (d[i])
    );
  end

  // decoded helpers
  assign stop     = d[`PRS_IN_STOP];
  assign fitted   = st.ctrl[`PRS_CTRL_TMR_FIT];
  assign bypass   = st.ctrl[`PRS_CTRL_BYPASS];
  assign lock     = st.ctrl[`PRS_CTRL_LOCKOUT] & d[`PRS_IN_LOCK];
  assign auto_req = d[`PRS_IN_PLOW] |
                    (st.ctrl[`PRS_CTRL_DELUGE] & ~d[`PRS_IN_DELUGE]);
  assign hold     = (st.tmr != TMR_DONE) | bypass | ~fitted;
  assign limit    = {2'b00, 14'(st.minutes) * `PRS_SECS_PER_MIN};
  assign setup    = PSEL_I & ~PENABLE_I;
  assign wr       = PSEL_I & PENABLE_I & st.pready & PWRITE_I;

  always_comb begin
    next_st = st;

    // apb: read data prepared in setup so pready and prdata leave flops
    next_st.pready  = setup;
    next_st.pslverr = 1'b0;
    next_st.prdata  = 32'h0;
    if (setup) begin
      case (PADDR_I)
        `PRS_ADDR_CTRL: begin
          next_st.prdata = {28'h0, st.ctrl};
        end
        `PRS_ADDR_TIMER: begin
          next_st.prdata = {st.run_sec, 8'h0, st.minutes};
        end
        `PRS_ADDR_STATUS: begin
          next_st.prdata = {20'h0, st.tmr == TMR_RUN, st.revs_alarm,
                            st.loss_alarm, st.pump_alarm, st.contactor,
                            st.manual, st.auto_run, st.tmr == TMR_DONE,
                            st.delay_done, st.ph_ok, st.rot_ok, st.line_q};
        end
        default: begin
          next_st.pslverr = 1'b1;
        end
      endcase
    end
    if (wr) begin
      case (PADDR_I)
        `PRS_ADDR_CTRL: begin
          next_st.ctrl = PWDATA_I[3:0];
        end
        `PRS_ADDR_TIMER: begin
          next_st.minutes = PWDATA_I[7:0];
        end
        default: begin
          next_st.ctrl = st.ctrl;
        end
      endcase
    end

    // phase monitor: phase loss leaves rotation asserted
    next_st.line_q = d[`PRS_IN_LINE];
    next_st.rot_ok = d[`PRS_IN_LINE] &
                     (~d[`PRS_IN_ALLP] | d[`PRS_IN_SEQ]);
    next_st.ph_ok  = d[`PRS_IN_LINE] & d[`PRS_IN_ALLP];

    // power-up delay restarts whenever the line goes dead
    if (!d[`PRS_IN_LINE]) begin
      next_st.pwr_cnt    = 32'h0;
      next_st.delay_done = 1'b0;
    end else if (!st.delay_done) begin
      if (st.pwr_cnt == 32'(PWRUP_CYCLES - 1)) begin
        next_st.delay_done = 1'b1;
      end else begin
        next_st.pwr_cnt = st.pwr_cnt + 32'h1;
      end
    end

    // lamps and relays; the reversal lamp is lit until the delay proves rotation
    next_st.rev_lamp  = st.line_q & (~st.delay_done | ~st.rot_ok);
    next_st.rev_relay = st.delay_done & ~st.rot_ok;
    next_st.pwr_lamp  = st.delay_done & st.ph_ok;
    next_st.pwr_relay = st.delay_done & st.ph_ok;

    // alarm contacts
    next_st.pump_alarm = st.contactor;
    next_st.loss_alarm = ~st.ph_ok | ~d[`PRS_IN_CPWR];
    next_st.revs_alarm = st.line_q & ~st.rot_ok;

    // auto run: request, or latched while the timer has not expired
    next_st.auto_run = ~stop & ~lock &
                       (auto_req | (st.auto_run & hold));

    // manual latch from local or remote start
    next_st.manual = ~stop & (d[`PRS_IN_START] | d[`PRS_IN_REMOTE] |
                              st.manual);

    // emergency run bypasses stop, as the mechanical handle would
    next_st.contactor = d[`PRS_IN_EMERG] |
                        (~stop & (st.auto_run | st.manual));

    // minimum-run timer, one-second prescaler
    case (st.tmr)
      TMR_IDLE: begin
        if (st.auto_run & fitted & ~bypass) begin
          next_st.tmr     = TMR_RUN;
          next_st.sec_cnt = 32'h0;
          next_st.run_sec = 16'h0;
        end
      end
      TMR_RUN: begin
        if (!st.auto_run) begin
          next_st.tmr = TMR_IDLE;
        end else if (st.sec_cnt == 32'(SEC_CYCLES - 1)) begin
          next_st.sec_cnt = 32'h0;
          next_st.run_sec = st.run_sec + 16'h1;
          if (st.run_sec + 16'h1 >= limit) begin
            next_st.tmr = TMR_DONE;
          end
        end else begin
          next_st.sec_cnt = st.sec_cnt + 32'h1;
        end
      end
      TMR_DONE: begin
        if (!st.auto_run) begin
          next_st.tmr = TMR_IDLE;
        end
      end
      default: begin
        next_st.tmr = TMR_IDLE;
      end
    endcase

    // synchronous reset: everything off, timer default, timer fitted
    if (!NRST_I) begin
      next_st         = '0;
      next_st.tmr     = TMR_IDLE;
      next_st.ctrl    = `PRS_CTRL_RST;
      next_st.minutes = `PRS_RUN_MIN_RST;
    end
  end

  always_ff @(posedge MCLK_I) begin
    st <= next_st;
  end

  // outputs straight from the state flops
  assign PREADY_O           = st.pready;
  assign PSLVERR_O          = st.pslverr;
  assign PRDATA_O           = st.prdata;
  assign ROT_OK_O           = st.rot_ok;
  assign PHASE_PRESENT_O    = st.ph_ok;
  assign REV_LAMP_O         = st.rev_lamp;
  assign REV_RELAY_O        = st.rev_relay;
  assign POWER_LAMP_O       = st.pwr_lamp;
  assign POWER_RELAY_O      = st.pwr_relay;
  assign AUTO_RUN_O         = st.auto_run;
  assign CONTACTOR_O        = st.contactor;
  assign PUMP_RUN_ALARM_O   = st.pump_alarm;
  assign PHASE_LOSS_ALARM_O = st.loss_alarm;
  assign PHASE_REV_ALARM_O  = st.revs_alarm;

  // checks on the design's own behaviour
  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (!NRST_I);

  sequence s_all_good;
    d[`PRS_IN_LINE] && d[`PRS_IN_ALLP] && d[`PRS_IN_SEQ];
  endsequence

  sequence s_auto_start;
    !st.auto_run && d[`PRS_IN_PLOW] && !stop && !lock;
  endsequence

  sequence s_timing;
    st.auto_run && st.tmr == TMR_RUN && !stop && !lock;
  endsequence

  a_mon_all_good: assert property (s_all_good |=> st.rot_ok && st.ph_ok)
    else $error("monitor outputs low with good phases");
  a_mon_phase_loss: assert property (d[`PRS_IN_LINE] && !d[`PRS_IN_ALLP]
    |=> st.rot_ok && !st.ph_ok)
    else $error("phase loss handled wrong");
  a_mon_reversal: assert property (d[`PRS_IN_LINE] && d[`PRS_IN_ALLP] &&
    !d[`PRS_IN_SEQ] |=> !st.rot_ok && st.ph_ok)
    else $error("reversal handled wrong");
  a_mon_total_loss: assert property (!d[`PRS_IN_LINE]
    |=> !st.rot_ok && !st.ph_ok)
    else $error("total loss handled wrong");
  a_delay_count: assert property ($rose(st.delay_done)
    |-> $past(st.pwr_cnt) == 32'(PWRUP_CYCLES - 1) && $past(st.line_q, 1))
    else $error("power-up delay length wrong");
  a_rev_indicate: assert property (st.delay_done && !st.rot_ok
    |=> st.rev_lamp && st.rev_relay)
    else $error("reversal not indicated");
  a_power_avail: assert property (st.delay_done && st.ph_ok
    |=> st.pwr_lamp && st.pwr_relay)
    else $error("power available not indicated");
  a_auto_start: assert property (s_auto_start |=> st.auto_run ##1
    (st.contactor || $past(stop)))
    else $error("auto start failed");
  a_timer_latch: assert property (s_timing |=> st.auto_run)
    else $error("auto run dropped while timing");
  a_stop_now: assert property (stop && !d[`PRS_IN_EMERG]
    |=> !st.contactor && !st.auto_run && !st.manual)
    else $error("stop did not stop the motor");
  a_manual_set: assert property (d[`PRS_IN_START] && !stop |=> st.manual)
    else $error("start did not set manual latch");
  a_lockout_rel: assert property (lock |=> !st.auto_run)
    else $error("lockout did not release auto run");
  a_emerg_hold: assert property (d[`PRS_IN_EMERG] |=> st.contactor)
    else $error("emergency run did not close contactor");
  a_pump_alarm: assert property (st.pump_alarm == $past(st.contactor))
    else $error("pump run alarm does not follow contactor");
  a_auto_release: assert property (st.auto_run && st.tmr == TMR_DONE && fitted
    && !bypass && !auto_req |=> !st.auto_run)
    else $error("auto run held after timer expiry");
  a_bypass_hold: assert property (st.auto_run && (bypass || !fitted) && !stop
    && !lock |=> st.auto_run)
    else $error("auto run dropped without timer");
  a_remote_set: assert property (d[`PRS_IN_REMOTE] && !stop
    |=> st.manual)
    else $error("remote start did not set manual latch");
  a_deluge_req: assert property (st.ctrl[`PRS_CTRL_DELUGE] && !d[`PRS_IN_DELUGE]
    && !stop && !lock |=> st.auto_run)
    else $error("deluge request did not start auto run");
  a_loss_alarm: assert property (!st.ph_ok || !d[`PRS_IN_CPWR]
    |=> st.loss_alarm)
    else $error("phase loss alarm not given");
  a_rev_alarm: assert property (st.line_q && !st.rot_ok
    |=> st.revs_alarm)
    else $error("phase reversal alarm not given");
  a_run_off: assert property (!d[`PRS_IN_EMERG] && !st.auto_run && !st.manual
    |=> !st.contactor)
    else $error("contactor closed with no run source");
endmodule
`default_nettype wire

// >>> tb/prs_field.sv
// field-side model: contacts and pushbuttons that chatter once on every change
`timescale 1ns/1ps
`default_nettype none
module prs_field (
  // clock
  input  wire logic        clk_i,
  // contact levels the bench asks for
  input  wire logic [10:0] want_i,
  // contact pins toward the sequencer
  output logic [10:0]      pin_o
);
  logic [10:0] last;
  logic [10:0] hop;

  // start as the bench starts: control power on, deluge switch closed
  initial begin
    last  = 11'h108;
    hop   = 11'h000;
    pin_o = 11'h108;
  end

  // a changed contact bounces back for one cycle, as real contacts do
  always @(posedge clk_i) begin
    last  <= want_i;
    hop   <= want_i ^ last;
    pin_o <= want_i ^ hop;
  end
endmodule
`default_nettype wire

// >>> tb/tb_top.sv
// self-checking bench for the pump run sequencer
`timescale 1ns/1ps
`default_nettype none
`include "prs_params.svh"
module tb_top;
  import prs_pkg::*;
  logic        clk;
  logic        nrst;
  logic        psel;
  logic        pen;
  logic        pwr;
  logic        prdy;
  logic        perr;
  logic        err;
  logic [7:0]  paddr;
  logic [31:0] pwd;
  logic [31:0] prd;
  logic [31:0] rd;
  logic [10:0] want;
  logic [10:0] pin;
  logic [10:0] so;
  int          fail_count;
  int          checks_done;
  int          m_auto;
  int          m_man;
  int unsigned rnd;
  logic [3:0]  q[$];
  int          pb[2];

  // design with short delay, debounce and second counts
  prs_sequencer #(.PWRUP_CYCLES(20), .DEB_CYCLES(3), .SEC_CYCLES(5)) prs_sequencer_i (
    .MCLK_I(clk), .NRST_I(nrst), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr),
    .PADDR_I(paddr), .PWDATA_I(pwd), .PREADY_O(prdy), .PSLVERR_O(perr), .PRDATA_O(prd),
    .LINE_LIVE_I(pin[0]), .PHASES_ALL_I(pin[1]), .SEQ_ABC_I(pin[2]), .CTRL_PWR_I(pin[3]),
    .PRESSURE_LOW_I(pin[4]), .STOP_PB_I(pin[5]), .START_PB_I(pin[6]),
    .REMOTE_START_I(pin[7]), .DELUGE_CLOSED_I(pin[8]), .LOCKOUT_I(pin[9]),
    .EMERG_RUN_I(pin[10]), .ROT_OK_O(so[10]), .PHASE_PRESENT_O(so[9]),
    .REV_LAMP_O(so[8]), .REV_RELAY_O(so[7]), .POWER_LAMP_O(so[6]), .POWER_RELAY_O(so[5]),
    .AUTO_RUN_O(so[4]), .CONTACTOR_O(so[3]), .PUMP_RUN_ALARM_O(so[2]),
    .PHASE_LOSS_ALARM_O(so[1]), .PHASE_REV_ALARM_O(so[0]));

  prs_field prs_field_i (.clk_i(clk), .want_i(want), .pin_o(pin));

  // 40 MHz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // one apb transfer; never assumes the answer latency
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (prdy !== 1'b1 && n < 20);
    if (n >= 20) begin
      fail_count++;
      print_verdict();
    end else begin
      rd = prd;
      err = perr;
      psel <= 1'b0;
      pen <= 1'b0;
      @(posedge clk);
    end
  endtask

  // move one contact and let synchroniser, debounce and logic settle
  task automatic step(input int i, input logic v);
    want[i] <= v;
    repeat (50) @(posedge clk);
  endtask

  // reference model of all field outputs, valid once the power-up delay is over
  task automatic chk_out();
    logic l, r, p, c;
    l = want[`PRS_IN_LINE];
    r = l & want[`PRS_IN_SEQ];
    p = l & want[`PRS_IN_ALLP];
    c = (m_auto != 0) | (m_man != 0) | want[`PRS_IN_EMERG];
    chk("outputs", {21'h0, so}, {21'h0, r, p, l & !r, l & !r, p, p, m_auto != 0, c, c,
        !p | !want[`PRS_IN_CPWR], l & !r});
  endtask

  // time limit for the whole run
  initial begin
    repeat (100000) @(posedge clk);
    fail_count++;
    print_verdict();
  end

  // main sequence
  initial begin
    psel = 1'b0;
    pen = 1'b0;
    pwr = 1'b0;
    paddr = 8'h00;
    pwd = 32'h0;
    want = 11'h108;
    nrst = 1'b0;
    m_auto = 0;
    m_man = 0;
    rnd = $urandom(95876);
    repeat (12) @(posedge clk);
    chk("reset", {29'h0, prdy, so[4], so[3]}, 32'h0);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    chk_out();
    // registers: reset values, unmapped place, minutes writable
    apb(1'b0, `PRS_ADDR_CTRL, 32'h0);
    chk("ctrl", rd, 32'h1);
    apb(1'b0, `PRS_ADDR_TIMER, 32'h0);
    chk("minutes", {24'h0, rd[7:0]}, 32'ha);
    apb(1'b0, 8'h0c, 32'h0);
    chk("unmapped", {err, rd[30:0]}, 32'h80000000);
    // random upper bits must be ignored by the minutes field
    rnd = $urandom;
    apb(1'b1, `PRS_ADDR_TIMER, {rnd[23:0], 8'h01});
    apb(1'b0, `PRS_ADDR_TIMER, 32'h0);
    chk("minutes", {16'h0, rd[15:0]}, 32'h1);
    // power-up: lamp state inside the delay, then after it
    want <= want | 11'h007;
    repeat (14) @(posedge clk);
    chk("delay", {30'h0, so[8], so[6]}, 32'h2);
    repeat (50) @(posedge clk);
    chk_out();
    // status: line, rotation, phases and delay done, nothing else
    apb(1'b0, `PRS_ADDR_STATUS, 32'h0);
    chk("status", rd, 32'h0000000f);
    // phase cases {cpwr, seq, allp, line}
    q = '{4'b1101, 4'b1011, 4'b1111, 4'b1110, 4'b1111, 4'b0111, 4'b1111};
    foreach (q[i]) begin
      want <= {want[10:4], q[i]};
      repeat (50) @(posedge clk);
      chk_out();
    end
    // automatic start, one-minute timer holds after pressure recovers
    step(`PRS_IN_PLOW, 1'b1);
    m_auto = 1;
    chk_out();
    // status while timing: auto run, contactor, pump alarm, timer running
    apb(1'b0, `PRS_ADDR_STATUS, 32'h0);
    chk("status", rd, 32'h000009af);
    step(`PRS_IN_PLOW, 1'b0);
    repeat (100) @(posedge clk);
    chk_out();
    repeat (250) @(posedge clk);
    m_auto = 0;
    chk_out();
    // stop while the timer is still timing
    step(`PRS_IN_PLOW, 1'b1);
    step(`PRS_IN_PLOW, 1'b0);
    step(`PRS_IN_STOP, 1'b1);
    chk_out();
    step(`PRS_IN_STOP, 1'b0);
    // bypass jumper, then no timer fitted: run until stop
    for (int k = 0; k < 2; k++) begin
      apb(1'b1, `PRS_ADDR_CTRL, (k == 0) ? 32'h3 : 32'h0);
      step(`PRS_IN_PLOW, 1'b1);
      step(`PRS_IN_PLOW, 1'b0);
      repeat (400) @(posedge clk);
      m_auto = 1;
      chk_out();
      step(`PRS_IN_STOP, 1'b1);
      m_auto = 0;
      chk_out();
      step(`PRS_IN_STOP, 1'b0);
    end
    // start pushbutton and remote start share the self-holding latch
    pb = '{`PRS_IN_START, `PRS_IN_REMOTE};
    foreach (pb[i]) begin
      step(pb[i], 1'b1);
      step(pb[i], 1'b0);
      m_man = 1;
      chk_out();
      step(`PRS_IN_STOP, 1'b1);
      m_man = 0;
      chk_out();
      step(`PRS_IN_STOP, 1'b0);
    end
    // deluge ignored when not fitted, then requests auto run
    apb(1'b1, `PRS_ADDR_CTRL, 32'h1);
    step(`PRS_IN_DELUGE, 1'b0);
    chk_out();
    step(`PRS_IN_DELUGE, 1'b1);
    apb(1'b1, `PRS_ADDR_CTRL, 32'h5);
    step(`PRS_IN_DELUGE, 1'b0);
    m_auto = 1;
    chk_out();
    step(`PRS_IN_DELUGE, 1'b1);
    chk_out();
    repeat (400) @(posedge clk);
    m_auto = 0;
    chk_out();
    // lockout releases auto run, restarts while pressure stays low
    apb(1'b1, `PRS_ADDR_CTRL, 32'h9);
    step(`PRS_IN_PLOW, 1'b1);
    m_auto = 1;
    step(`PRS_IN_LOCK, 1'b1);
    m_auto = 0;
    chk_out();
    step(`PRS_IN_LOCK, 1'b0);
    m_auto = 1;
    chk_out();
    step(`PRS_IN_PLOW, 1'b0);
    repeat (400) @(posedge clk);
    m_auto = 0;
    chk_out();
    // emergency handle holds the contactor through a stop press
    step(`PRS_IN_EMERG, 1'b1);
    step(`PRS_IN_STOP, 1'b1);
    chk_out();
    step(`PRS_IN_STOP, 1'b0);
    step(`PRS_IN_EMERG, 1'b0);
    chk_out();
    print_verdict();
  end
endmodule
`default_nettype wire
